// >>> rtl/wsq_pkg.sv
// Purpose: Shared constants and carrier types for the register write sequencer.
// Assumes: Control interface delivers decoded 16-bit register reads and writes.
// Notes: Register offsets are word addresses on the control interface.
//
// What this block does
// - Sequencer runs only while enable bit 15 of the control register is 1.
// - Writing 1 to abort bit 9 stops the sequence and returns control.
// - Writing 1 to launch bit 8 starts execution at the first-command slot.
// - Execution continues through successive stored commands until an end marker.
// - Sequencer clears the launch bit itself when a sequence completes.
// - Seven-bit first-command slot field in bits 6:0, reset to zero.
// - Bits 10:4 of status report the most recently accessed slot.
// - Read-only running flag at status bit 0, 1 while active.
// - Control-interface register writes other than abort are ignored while the running flag is 1.
// - In 4-wire mode bit 5 picks push-pull or open-drain serial output.
// - Bit 4 selects 3-wire read-back on input pin or 4-wire on output pin.
// - Alert response protocol answered only when bit 3 is 1; resets to 0.
// - Bit 1 enables address auto-increment in multi-word transfers; resets to 1.
package wsq_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0] WSQ_ADDR_CONTROL = 8'h26;
   localparam logic [7:0] WSQ_ADDR_STATUS = 8'h27;
   localparam logic [7:0] WSQ_ADDR_PORT_CFG = 8'h28;

   // ==========================================================
   // Field positions
   localparam int WSQ_BIT_ENABLE = 15;
   localparam int WSQ_BIT_ABORT = 9;
   localparam int WSQ_BIT_LAUNCH = 8;
   localparam int WSQ_SLOT_LSB = 0;
   localparam int WSQ_CUR_LSB = 4;
   localparam int WSQ_BIT_RUNNING = 0;
   localparam int WSQ_BIT_OPEN_DRAIN = 5;
   localparam int WSQ_BIT_FOUR_WIRE = 4;
   localparam int WSQ_BIT_ALERT_EN = 3;
   localparam int WSQ_BIT_AUTO_INC = 1;

   // ==========================================================
   // Widths and reset values
   localparam int WSQ_SLOT_W = 7;
   localparam int WSQ_DATA_W = 16;
   localparam int WSQ_ADDR_W = 8;
   localparam logic [6:0] WSQ_SLOT_RESET = 7'h00;
   localparam logic WSQ_AUTO_INC_RESET = 1'b1;

   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic end_of_seq;
      logic [7:0] addr;
      logic [15:0] data;
   } wsq_cmd_t;

   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [15:0] data;
   } wsq_wr_t;

   typedef enum logic [1:0] {
      WSQ_IDLE,
      WSQ_FETCH,
      WSQ_ISSUE
   } wsq_state_t;

endpackage

// >>> rtl/wsq_sequencer.sv
// Purpose: Control write sequencer and control-port configuration registers.
// Assumes: Serial engine outside decodes frames into word reads and writes.
// Notes: Command memory is loaded through its own port; writes leave on wr_out.
//        The running flag has its own flop so the status output never glitches.
`timescale 1ns/1ps
`default_nettype none
module wsq_sequencer import wsq_pkg::*; #(
   parameter int DEPTH = 128
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Control interface word access
   input wire logic ctl_wr,
   input wire logic ctl_rd,
   input wire logic [7:0] ctl_addr,
   input wire logic [15:0] ctl_wdata,
   output logic [15:0] ctl_rdata,
   // Command memory load port
   input wire logic mem_wr,
   input wire logic [6:0] mem_slot,
   input wire wsq_cmd_t mem_cmd,
   // Register writes toward the device core
   output wsq_wr_t wr_out,
   // Serial engine read-back bit and transfer events
   input wire logic rd_drive,
   input wire logic rd_bit,
   input wire logic word_done,
   input wire logic alert_hit,
   output logic addr_advance,
   output logic alert_ack,
   // Serial input pin, bidirectional in 3-wire mode
   input wire logic serial_data_in_pin_i,
   output logic serial_data_in_pin_o,
   output logic serial_data_in_pin_oe,
   output logic serial_in_sync,
   // Serial output pin
   output logic serial_data_out_pin_o,
   output logic serial_data_out_pin_oe,
   // Configuration view
   output logic four_wire_select,
   output logic sequencer_running
);

   // ==========================================================
   // Storage and state
   wsq_cmd_t mem [DEPTH];
   wsq_state_t state_r, state_nxt;
   logic sequencer_enable_r, sequencer_enable_nxt;
   logic sequence_launch_r, sequence_launch_nxt;
   logic [6:0] first_command_slot_r, first_command_slot_nxt;
   logic [6:0] slot_r, slot_nxt;
   logic [6:0] last_accessed_slot_r, last_accessed_slot_nxt;
   wsq_cmd_t cmd_r, cmd_nxt;
   logic open_drain_r, open_drain_nxt;
   logic four_wire_r, four_wire_nxt;
   logic alert_response_enable_r, alert_response_enable_nxt;
   logic auto_inc_r, auto_inc_nxt;
   wsq_wr_t wr_r, wr_nxt;
   logic [15:0] rdata_r, rdata_nxt;
   logic sin_meta_r, sin_sync_r;
   logic sdo_o_r, sdo_oe_r, sdi_o_r, sdi_oe_r, sdo_o_nxt, sdo_oe_nxt, sdi_o_nxt, sdi_oe_nxt;
   logic adv_r, ack_r;
   // Running flag kept in its own flop; it mirrors the state register.
   logic running_r, running_nxt;

   // ==========================================================
   // Write gating: host writes are accepted only while idle, but an
   // abort must reach the sequencer even while it owns the register port.
   logic running;
   logic host_wr;
   logic abort_req;
   assign running = (state_r != WSQ_IDLE);
   assign host_wr = ctl_wr && !running;
   assign abort_req = ctl_wr && (ctl_addr == WSQ_ADDR_CONTROL) && ctl_wdata[WSQ_BIT_ABORT];

   // ==========================================================
   // Returns a register's read value.
   function automatic logic [15:0] read_reg(input logic [7:0] a);
      logic [15:0] v;
      v = '0;
      unique case (a)
         WSQ_ADDR_CONTROL: begin
            v[WSQ_BIT_ENABLE] = sequencer_enable_r;
            v[WSQ_BIT_LAUNCH] = sequence_launch_r;
            v[WSQ_SLOT_LSB +: WSQ_SLOT_W] = first_command_slot_r;
         end
         WSQ_ADDR_STATUS: begin
            v[WSQ_CUR_LSB +: WSQ_SLOT_W] = last_accessed_slot_r;
            v[WSQ_BIT_RUNNING] = running;
         end
         WSQ_ADDR_PORT_CFG: begin
            v[WSQ_BIT_OPEN_DRAIN] = open_drain_r;
            v[WSQ_BIT_FOUR_WIRE] = four_wire_r;
            v[WSQ_BIT_ALERT_EN] = alert_response_enable_r;
            v[WSQ_BIT_AUTO_INC] = auto_inc_r;
         end
         default: v = '0;
      endcase
      return v;
   endfunction

   // Extracts the first-command slot field from a control word.
   function automatic logic [6:0] slot_field(input logic [15:0] d);
      return d[WSQ_SLOT_LSB +: WSQ_SLOT_W];
   endfunction

   // Packs one write toward the core so host and sequencer writes look alike.
   function automatic wsq_wr_t make_wr(input logic [7:0] a, input logic [15:0] d);
      wsq_wr_t w;
      w.valid = 1'b1;
      w.addr = a;
      w.data = d;
      return w;
   endfunction

   // ==========================================================
   // Command memory is written only through the load port.
   // The load port is not blocked while running; do not reload a live slot.
   always_ff @(posedge clk) begin
      if (mem_wr) begin
         mem[mem_slot] <= mem_cmd;
      end
   end

   // ==========================================================
   // Next-state logic for registers and the sequencer.
   always_comb begin
      state_nxt = state_r;
      sequencer_enable_nxt = sequencer_enable_r;
      sequence_launch_nxt = sequence_launch_r;
      first_command_slot_nxt = first_command_slot_r;
      slot_nxt = slot_r;
      last_accessed_slot_nxt = last_accessed_slot_r;
      cmd_nxt = cmd_r;
      open_drain_nxt = open_drain_r;
      four_wire_nxt = four_wire_r;
      alert_response_enable_nxt = alert_response_enable_r;
      auto_inc_nxt = auto_inc_r;
      wr_nxt = '0;
      rdata_nxt = rdata_r;
      if (ctl_rd) begin
         rdata_nxt = read_reg(ctl_addr);
      end
      // Host writes while idle; local registers are held, others pass on.
      // Writes to the read-only status register change nothing.
      if (host_wr) begin
         unique case (ctl_addr)
            WSQ_ADDR_CONTROL: begin
               sequencer_enable_nxt = ctl_wdata[WSQ_BIT_ENABLE];
               first_command_slot_nxt = slot_field(ctl_wdata);
               if (ctl_wdata[WSQ_BIT_LAUNCH] && ctl_wdata[WSQ_BIT_ENABLE]
                     && !ctl_wdata[WSQ_BIT_ABORT]) begin
                  sequence_launch_nxt = 1'b1;
                  slot_nxt = slot_field(ctl_wdata);
                  state_nxt = WSQ_FETCH;
               end
            end
            WSQ_ADDR_STATUS: begin
               // Read-only register; writes are dropped.
            end
            WSQ_ADDR_PORT_CFG: begin
               open_drain_nxt = ctl_wdata[WSQ_BIT_OPEN_DRAIN];
               four_wire_nxt = ctl_wdata[WSQ_BIT_FOUR_WIRE];
               alert_response_enable_nxt = ctl_wdata[WSQ_BIT_ALERT_EN];
               auto_inc_nxt = ctl_wdata[WSQ_BIT_AUTO_INC];
            end
            default: begin
               wr_nxt = make_wr(ctl_addr, ctl_wdata);
            end
         endcase
      end
      // Sequencer walk through the command memory.
      unique case (state_r)
         WSQ_IDLE: begin
            // Nothing to do until a launch is accepted.
         end
         WSQ_FETCH: begin
            // Fetch reads the slot and records it as the last one accessed.
            cmd_nxt = mem[slot_r];
            last_accessed_slot_nxt = slot_r;
            state_nxt = WSQ_ISSUE;
         end
         WSQ_ISSUE: begin
            // Issue sends the command; the end marker hands the port back.
            wr_nxt = make_wr(cmd_r.addr, cmd_r.data);
            if (cmd_r.end_of_seq) begin
               state_nxt = WSQ_IDLE;
               sequence_launch_nxt = 1'b0;
            end else begin
               // The slot counter wraps from the last slot back to slot zero.
               slot_nxt = slot_r + 7'h01;
               state_nxt = WSQ_FETCH;
            end
         end
      endcase
      // Abort is honoured even while running and cancels any pending write.
      // A launch written together with the abort bit is refused, so abort wins.
      if (abort_req) begin
         if (running) begin
            wr_nxt = '0;
         end
         state_nxt = WSQ_IDLE;
         sequence_launch_nxt = 1'b0;
      end
      // The running flag follows the final next state of the sequencer.
      running_nxt = (state_nxt != WSQ_IDLE);
   end

   // ==========================================================
   // Pin drive: 3-wire reads back on the input pin, 4-wire on the output pin.
   // The drive lags rd_drive by one cycle because it is registered.
   always_comb begin
      sdi_o_nxt = 1'b0;
      sdi_oe_nxt = 1'b0;
      sdo_o_nxt = 1'b0;
      sdo_oe_nxt = 1'b0;
      if (rd_drive) begin
         if (four_wire_r) begin
            if (open_drain_r) begin
               // Open drain only pulls low: the enable carries the inverted bit.
               sdo_oe_nxt = !rd_bit;
            end else begin
               sdo_o_nxt = rd_bit;
               sdo_oe_nxt = 1'b1;
            end
         end else begin
            sdi_o_nxt = rd_bit;
            sdi_oe_nxt = 1'b1;
         end
      end
   end

   // ==========================================================
   // Registers for all groups.
   // Reset is synchronous, so the reset branch assigns constants only.
   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= WSQ_IDLE;
         sequencer_enable_r <= 1'b0;
         sequence_launch_r <= 1'b0;
         first_command_slot_r <= WSQ_SLOT_RESET;
         slot_r <= WSQ_SLOT_RESET;
         last_accessed_slot_r <= WSQ_SLOT_RESET;
         cmd_r <= '0;
         open_drain_r <= 1'b0;
         four_wire_r <= 1'b0;
         alert_response_enable_r <= 1'b0;
         auto_inc_r <= WSQ_AUTO_INC_RESET;
         wr_r <= '0;
         rdata_r <= '0;
         sin_meta_r <= 1'b0;
         sin_sync_r <= 1'b0;
         sdo_o_r <= 1'b0;
         sdo_oe_r <= 1'b0;
         sdi_o_r <= 1'b0;
         sdi_oe_r <= 1'b0;
         adv_r <= 1'b0;
         ack_r <= 1'b0;
         running_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         sequencer_enable_r <= sequencer_enable_nxt;
         sequence_launch_r <= sequence_launch_nxt;
         first_command_slot_r <= first_command_slot_nxt;
         slot_r <= slot_nxt;
         last_accessed_slot_r <= last_accessed_slot_nxt;
         cmd_r <= cmd_nxt;
         open_drain_r <= open_drain_nxt;
         four_wire_r <= four_wire_nxt;
         alert_response_enable_r <= alert_response_enable_nxt;
         auto_inc_r <= auto_inc_nxt;
         wr_r <= wr_nxt;
         rdata_r <= rdata_nxt;
         sin_meta_r <= serial_data_in_pin_i;
         sin_sync_r <= sin_meta_r;
         sdo_o_r <= sdo_o_nxt;
         sdo_oe_r <= sdo_oe_nxt;
         sdi_o_r <= sdi_o_nxt;
         sdi_oe_r <= sdi_oe_nxt;
         adv_r <= word_done && auto_inc_r;
         ack_r <= alert_hit && alert_response_enable_r;
         running_r <= running_nxt;
      end
   end

   // ==========================================================
   // Outputs straight from flip-flops.
   assign ctl_rdata = rdata_r;
   assign wr_out = wr_r;
   assign addr_advance = adv_r;
   assign alert_ack = ack_r;
   assign serial_data_in_pin_o = sdi_o_r;
   assign serial_data_in_pin_oe = sdi_oe_r;
   assign serial_in_sync = sin_sync_r;
   assign serial_data_out_pin_o = sdo_o_r;
   assign serial_data_out_pin_oe = sdo_oe_r;
   assign four_wire_select = four_wire_r;
   assign sequencer_running = running_r;

endmodule
`default_nettype wire

// >>> verif/wsq_host_model.sv
// Purpose: Serial engine and host stand-in on the far side of the sequencer.
// Assumes: Events change 1 ns after each rising clock edge.
// Notes: The host bit toggles every cycle so a released pin never looks held.
`timescale 1ns/1ps
`default_nettype none
module wsq_host_model (
   // Clock and activity switch
   input wire logic clk,
   input wire logic en,
   // Serial engine events
   output logic rd_drive,
   output logic rd_bit,
   output logic word_done,
   output logic alert_hit,
   // Shared serial input pin
   input wire logic pin_o,
   input wire logic pin_oe,
   output logic pin_i
);
   logic host_bit;
   // ==========================================================
   // Random events just after each edge while enabled.
   initial begin
      {rd_drive, rd_bit, word_done, alert_hit, host_bit} = 5'h00;
      forever begin
         @(posedge clk);
         #1;
         {rd_drive, rd_bit, word_done, alert_hit} = en ? 4'($urandom) : 4'h0;
         host_bit = !host_bit;
      end
   end
   // The host lets go of the pin while the device drives it.
   assign pin_i = pin_oe ? pin_o : host_bit;
endmodule
`default_nettype wire

// >>> verif/wsq_properties.sv
// Purpose: Port assertions for the write sequencer.
// Assumes: Bound to every sequencer instance.
// Notes: Latencies follow the hand-over timing.
`timescale 1ns/1ps
`default_nettype none
module wsq_props import wsq_pkg::*; (
   // Clock, reset and host writes
   input wire logic clk,
   input wire logic reset,
   input wire logic ctl_wr,
   input wire logic [7:0] ctl_addr,
   input wire logic [15:0] ctl_wdata,
   // Events and outputs
   input wire logic word_done,
   input wire logic alert_hit,
   input wire logic addr_advance,
   input wire logic alert_ack,
   input wire wsq_wr_t wr_out,
   input wire logic serial_data_in_pin_oe,
   input wire logic serial_data_out_pin_o,
   input wire logic serial_data_out_pin_oe,
   input wire logic four_wire_select,
   input wire logic sequencer_running
);
   // ==========================================================
   // Control register writes, sequencer progress, event answers and pin drive.
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   wire logic ctl_hit = ctl_wr && ctl_addr == WSQ_ADDR_CONTROL;
   property p_launch;
      ctl_hit && ctl_wdata[15] && ctl_wdata[8] && !ctl_wdata[9] && !sequencer_running
         |=> sequencer_running;
   endproperty
   a_launch: assert property (p_launch) else $error("launch did not start");
   property p_disabled;
      ctl_hit && !ctl_wdata[15] && !sequencer_running |=> !sequencer_running;
   endproperty
   a_disabled: assert property (p_disabled) else $error("ran while disabled");
   property p_abort;
      ctl_hit && ctl_wdata[9] |=> !sequencer_running && !wr_out.valid;
   endproperty
   a_abort: assert property (p_abort) else $error("abort not honoured");
   property p_end;
      $fell(sequencer_running) |-> wr_out.valid || $past(ctl_hit);
   endproperty
   a_end: assert property (p_end) else $error("stopped without cause");
   property p_first;
      $rose(sequencer_running) && !ctl_hit ##1 !ctl_hit |=> wr_out.valid;
   endproperty
   a_first: assert property (p_first) else $error("first command late");
   property p_gap;
      sequencer_running && wr_out.valid |=> !wr_out.valid;
   endproperty
   a_gap: assert property (p_gap) else $error("command issued without fetch");
   property p_adv;
      addr_advance |-> $past(word_done);
   endproperty
   a_adv: assert property (p_adv) else $error("advance without word end");
   property p_alert;
      alert_ack |-> $past(alert_hit);
   endproperty
   a_alert: assert property (p_alert) else $error("alert answer without cause");
   property p_outmode;
      serial_data_out_pin_oe |-> $past(four_wire_select);
   endproperty
   a_outmode: assert property (p_outmode) else $error("output pin in 3-wire");
   property p_inmode;
      serial_data_in_pin_oe |-> !$past(four_wire_select);
   endproperty
   a_inmode: assert property (p_inmode) else $error("input pin driven in 4-wire");
   property p_od;
      four_wire_select && serial_data_out_pin_o |-> serial_data_out_pin_oe;
   endproperty
   a_od: assert property (p_od) else $error("high level on released pin");
endmodule
bind wsq_sequencer wsq_props u_props (.clk, .reset, .ctl_wr, .ctl_addr, .ctl_wdata,
   .word_done, .alert_hit, .addr_advance, .alert_ack, .wr_out, .serial_data_in_pin_oe,
   .serial_data_out_pin_o, .serial_data_out_pin_oe, .four_wire_select, .sequencer_running);
`default_nettype wire

// >>> verif/tb.sv
// Purpose: Self-checking bench for the write sequencer.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: A queue model predicts every write leaving on wr_out.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import wsq_pkg::*;
   logic clk, reset, ctl_wr, ctl_rd, mem_wr, rd_drive, rd_bit, word_done, alert_hit;
   logic addr_advance, alert_ack, pin_i, in_o, in_oe, in_sync, out_o, out_oe, fws, running;
   logic host_en, wd, ah, dr, bt, pn, pp;
   logic [1:0] rsh;
   logic [7:0] ctl_addr;
   logic [15:0] ctl_wdata, ctl_rdata, cf, m_cfg;
   logic [6:0] mem_slot;
   wsq_cmd_t mem_cmd;
   wsq_cmd_t mem_m [128];
   wsq_wr_t wr_out;
   wsq_wr_t exp_q [$];
   int num_errors, num_checks, cycles, m_run;
   wsq_sequencer #(.DEPTH(128)) dut (.clk, .reset, .ctl_wr, .ctl_rd, .ctl_addr, .ctl_wdata,
      .ctl_rdata, .mem_wr, .mem_slot, .mem_cmd, .wr_out, .rd_drive, .rd_bit, .word_done,
      .alert_hit, .addr_advance, .alert_ack, .serial_data_in_pin_i(pin_i),
      .serial_data_in_pin_o(in_o), .serial_data_in_pin_oe(in_oe), .serial_in_sync(in_sync),
      .serial_data_out_pin_o(out_o), .serial_data_out_pin_oe(out_oe),
      .four_wire_select(fws), .sequencer_running(running));
   wsq_host_model host (.clk, .en(host_en), .rd_drive, .rd_bit, .word_done, .alert_hit,
      .pin_o(in_o), .pin_oe(in_oe), .pin_i);
   // ==========================================================
   // Clock at 100 MHz.
   initial begin
      clk = 1'b0;
      forever #5 clk = !clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want) begin
         num_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Register write; the model records its effect after the taking edge.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      {ctl_wr, ctl_addr, ctl_wdata} = {1'b1, a, d};
      @(posedge clk);
      #1;
      ctl_wr = 1'b0;
      if (d[9] && a == WSQ_ADDR_CONTROL) begin
         exp_q.delete();
         m_run = 0;
      end
      if (!m_run && a == WSQ_ADDR_PORT_CFG) m_cfg = d & 16'h003A;
      if (!m_run && (a < 8'h26 || a > 8'h28)) exp_q.push_back({1'b1, a, d});
      @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] want);
      {ctl_rd, ctl_addr} = {1'b1, a};
      @(posedge clk);
      #1;
      ctl_rd = 1'b0;
      check(ctl_rdata, want);
      @(posedge clk);
      #1;
   endtask
   // Loads n commands from slot s with wrap, then launches.
   task automatic run(input int s, input int n, input logic eos);
      int x;
      for (int k = 0; k < n; k++) begin
         x = (s + k) % 128;
         mem_m[x] = {eos && k == n - 1, 24'($urandom)};
         {mem_wr, mem_slot, mem_cmd} = {1'b1, 7'(x), mem_m[x]};
         @(posedge clk);
         #1;
         exp_q.push_back({1'b1, mem_m[x][23:0]});
      end
      // The load strobe stays up between slots and drops once after the last.
      mem_wr = 1'b0;
      wr(WSQ_ADDR_CONTROL, 16'h8100 | 16'(s));
      m_run = 1;
      check(running, 1'b1);
   endtask
   // Model comparison at every edge.
   always @(posedge clk) begin
      {wd, ah, dr, bt, cf, pp, pn} = {word_done, alert_hit, rd_drive, rd_bit, m_cfg, pn, pin_i};
      rsh = {rsh[0], reset};
      #2;
      if (++cycles > 20000) begin
         num_errors++;
         finish_test();
      end else if (rsh == 2'b00) begin
         check(addr_advance, wd & cf[1]);
         check(alert_ack, ah & cf[3]);
         check(in_sync, pp);
         check(fws, m_cfg[4]);
         if (!dr) check({in_oe, out_oe}, 2'b00);
         else if (!cf[4]) check({in_oe, in_o, out_oe}, {1'b1, bt, 1'b0});
         else check({in_oe, out_oe, out_o}, cf[5] ? {1'b0, !bt, 1'b0} : {1'b0, 1'b1, bt});
         if (wr_out.valid === 1'b1) check(wr_out, exp_q.size() ? exp_q.pop_front() : 25'h0);
      end
   end
   initial begin
      logic [15:0] d;
      {ctl_wr, ctl_rd, mem_wr, host_en, ctl_addr, ctl_wdata, mem_slot, mem_cmd} = '0;
      {m_cfg, m_run, rsh, pn} = {16'h0002, 32'h0, 2'h3, 1'b0};
      d = 16'($urandom(32'h52FF07A3));
      reset = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      reset = 1'b0;
      host_en = 1'b1;
      rd(WSQ_ADDR_CONTROL, 16'h0000);
      rd(WSQ_ADDR_PORT_CFG, 16'h0002);
      wr(WSQ_ADDR_STATUS, 16'hFFFF);
      rd(WSQ_ADDR_STATUS, 16'h0000);
      rd(8'h30, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         d = 16'($urandom);
         d[5:4] = 2'(i);
         wr(WSQ_ADDR_PORT_CFG, d);
         repeat (12) @(posedge clk);
         #1;
         rd(WSQ_ADDR_PORT_CFG, m_cfg);
      end
      wr(8'h10, 16'($urandom));
      run(125, 5, 1'b1);
      for (int k = 0; k < 100 && running !== 1'b0; k++) begin
         @(posedge clk);
         #1;
      end
      m_run = 0;
      rd(WSQ_ADDR_CONTROL, 16'h807D);
      rd(WSQ_ADDR_STATUS, 16'h0010);
      check(exp_q.size(), 0);
      wr(WSQ_ADDR_CONTROL, 16'h0105);
      check(running, 1'b0);
      run(2, 20, 1'b0);
      wr(8'h11, 16'h1234);
      wr(WSQ_ADDR_PORT_CFG, 16'h0000);
      wr(WSQ_ADDR_CONTROL, 16'h0200);
      check(running, 1'b0);
      repeat (6) @(posedge clk);
      #1;
      rd(WSQ_ADDR_PORT_CFG, m_cfg);
      finish_test();
   end
endmodule
`default_nettype wire
